// >>> rtl/rximc_pkg.sv
// receive completion and checksum block: shared constants
// assumes a 25 MHz core clock and a 32-bit APB register port
package rximc_pkg;
  // register byte addresses
  localparam logic [15:0] ADDR_PKT_DELAY = 16'h2820;
  localparam logic [15:0] ADDR_ABS_DELAY = 16'h282C;
  localparam logic [15:0] ADDR_SMALL_THR = 16'h2C00;
  localparam logic [15:0] ADDR_ACK_DELAY = 16'h2C08;
  localparam logic [15:0] ADDR_AUX_CTRL = 16'h2C10;
  localparam logic [15:0] ADDR_STATUS = 16'h2C14;
  localparam logic [15:0] ADDR_CSUM_CTRL = 16'h5000;
  // values after reset
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [11:0] SMALL_THR_RST = 12'h000;
  localparam logic [13:0] CSUM_CTRL_RST = 14'h0300;
  localparam logic [8:0] AUX_CTRL_RST = 9'h000;
  // checksum control fields
  localparam int CS_START_LSB = 0;
  localparam int CS_IP_EN = 8;
  localparam int CS_L4_EN = 9;
  localparam int CS_CRC_EN = 11;
  localparam int CS_IPP_MODE = 12;
  localparam int CS_REPORT_DIS = 13;
  // packet delay write: flush bit
  localparam int PKT_FLUSH_BIT = 31;
  // auxiliary control fields
  localparam int AUX_RX_EN = 0;
  localparam int AUX_STRIP_CRC = 1;
  localparam int AUX_VLAN_STRIP = 2;
  localparam int AUX_DTYPE_LSB = 3;
  localparam int AUX_V6_FILT_OFF = 5;
  localparam int AUX_V6_SUM_OFF = 6;
  localparam int AUX_SMALL_EN = 7;
  localparam int AUX_ACK_EN = 8;
  // descriptor types
  localparam logic [1:0] DTYPE_LEGACY = 2'h0;
  localparam logic [1:0] DTYPE_EXT = 2'h1;
  // timer tick: 1.024 us, least time so rounded up
  localparam int TICK_NS = 1024;
  localparam int CLK_NS = 40;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
endpackage

// >>> rtl/rximc_delay_timer.sv
// one countdown timer in 1.024 us ticks
// assumes i_tick is a one-cycle pulse from a shared prescaler
`timescale 1ns/10ps
`default_nettype none
module rximc_delay_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // control
  input wire logic i_tick,
  input wire logic i_load,
  input wire logic i_halt,
  input wire logic [W-1:0] i_value,
  // state
  output logic [W-1:0] o_count,
  output logic o_running,
  output logic o_expire
);
  logic [W-1:0] count;
  logic running;

  // expiry on the tick that takes the count from one to zero
  assign o_expire = running && i_tick && !i_halt && !i_load && (count == W'(1));
  assign o_count = count;
  assign o_running = running;

  // load restarts, halt reloads but stops; load wins over halt
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      count <= '0;
      running <= 1'b0;
    end
    else if (i_load)
    begin
      count <= i_value;
      running <= (i_value != '0);
    end
    else if (i_halt)
    begin
      count <= i_value;
      running <= 1'b0;
    end
    else if (running && i_tick)
    begin
      count <= count - W'(1);
      running <= (count != W'(1));
    end
  end
endmodule // rximc_delay_timer
`default_nettype wire

// >>> rtl/rximc_top.sv
// receive interrupt moderation and checksum reporting, APB slave
// assumes upstream parsing supplies a byte stream and per-packet flags
// How it works
// - absolute delay 16 bits, zero disables
// - absolute timer starts at first delivered packet
// - absolute expiry flushes and raises timer cause
// - packet expiry halts and reloads absolute timer
// - small packet at or under threshold interrupts
// - length counts CRC, not stripped VLAN
// - ACK loads dedicated 16-bit ACK timer
// - ACK interrupt on expiry, no reload
// - zero ACK delay interrupts at once
// - IP and L4 enables reset to one
// - legacy descriptors carry packet checksum
// - extended descriptors: checksum/ident or hash
// - raw ones-complement sum from start byte
// - stripped CRC bytes left out of sum
// - payload mode sums from IP payload
// - IPv4 header check reports error bit
// - TCP/UDP check reports error bit
// - IPv6 L4 check needs both v6 bits clear
// - offload only for Ethernet II and SNAP
// - CRC32 check reports CRC error bit
// - packet timer restarts per delivered packet
// - absolute expiry halts and reloads packet timer
`timescale 1ns/10ps
`default_nettype none
module rximc_top (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // receive byte stream
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_sop,
  input wire logic i_rx_eop,
  input wire logic i_rx_vlan_byte,
  input wire logic i_rx_crc_byte,
  // per-packet parse results, valid with i_rx_eop
  input wire logic [7:0] i_l3_payload_off,
  input wire logic i_encap_ok,
  input wire logic i_is_ipv4,
  input wire logic i_is_ipv6,
  input wire logic i_is_l4,
  input wire logic i_ip_hdr_ok,
  input wire logic i_l4_sum_ok,
  input wire logic i_crc_ok,
  input wire logic [15:0] i_ip_ident,
  input wire logic [31:0] i_rss_hash,
  // completion events
  input wire logic i_pkt_to_mem,
  input wire logic i_ack_pkt,
  // descriptor results
  output logic o_desc_valid,
  output logic [31:0] o_desc_info,
  output logic o_desc_ip_err,
  output logic o_desc_l4_err,
  output logic o_desc_crc_err,
  // interrupt causes and flush
  output logic o_rx_timer_irq,
  output logic o_flush_wb,
  output logic o_small_pkt_irq,
  output logic o_ack_irq
);
  // end-around-carry add for the ones-complement sum
  function automatic logic [15:0] csum_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  logic [15:0] abs_delay;
  logic [15:0] pkt_delay;
  logic [11:0] small_thr;
  logic [15:0] ack_delay;
  logic [13:0] csum_ctrl;
  logic [8:0] aux_ctrl;

  // apb decode; zero wait states
  logic setup_ph;
  logic wr_en;
  logic hit;
  logic fpd_wr;
  logic [31:0] next_rdata;
  logic [31:0] status_word;
  assign setup_ph = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign hit = (i_paddr == rximc_pkg::ADDR_ABS_DELAY) || (i_paddr == rximc_pkg::ADDR_PKT_DELAY)
    || (i_paddr == rximc_pkg::ADDR_SMALL_THR) || (i_paddr == rximc_pkg::ADDR_ACK_DELAY)
    || (i_paddr == rximc_pkg::ADDR_CSUM_CTRL) || (i_paddr == rximc_pkg::ADDR_AUX_CTRL)
    || (i_paddr == rximc_pkg::ADDR_STATUS);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;
  assign fpd_wr = wr_en && (i_paddr == rximc_pkg::ADDR_PKT_DELAY)
    && i_pwdata[rximc_pkg::PKT_FLUSH_BIT];

  // control fields
  logic rx_enable;
  logic strip_crc;
  logic vlan_strip_en;
  logic [1:0] rx_desc_type;
  logic v6_filter_off;
  logic v6_sum_off;
  logic small_pkt_en;
  logic ack_irq_en;
  logic [7:0] checksum_start_byte;
  logic ip_hdr_check_en;
  logic l4_check_en;
  logic crc32_check_en;
  logic ip_payload_sum_mode;
  logic checksum_report_disable;
  assign rx_enable = aux_ctrl[rximc_pkg::AUX_RX_EN];
  assign strip_crc = aux_ctrl[rximc_pkg::AUX_STRIP_CRC];
  assign vlan_strip_en = aux_ctrl[rximc_pkg::AUX_VLAN_STRIP];
  assign rx_desc_type = aux_ctrl[rximc_pkg::AUX_DTYPE_LSB +: 2];
  assign v6_filter_off = aux_ctrl[rximc_pkg::AUX_V6_FILT_OFF];
  assign v6_sum_off = aux_ctrl[rximc_pkg::AUX_V6_SUM_OFF];
  assign small_pkt_en = aux_ctrl[rximc_pkg::AUX_SMALL_EN];
  assign ack_irq_en = aux_ctrl[rximc_pkg::AUX_ACK_EN];
  assign checksum_start_byte = csum_ctrl[rximc_pkg::CS_START_LSB +: 8];
  assign ip_hdr_check_en = csum_ctrl[rximc_pkg::CS_IP_EN];
  assign l4_check_en = csum_ctrl[rximc_pkg::CS_L4_EN];
  assign crc32_check_en = csum_ctrl[rximc_pkg::CS_CRC_EN];
  assign ip_payload_sum_mode = csum_ctrl[rximc_pkg::CS_IPP_MODE];
  assign checksum_report_disable = csum_ctrl[rximc_pkg::CS_REPORT_DIS];

  // timer state
  logic tick;
  logic pkt_run;
  logic abs_run;
  logic ack_run;
  logic pkt_exp;
  logic abs_exp;
  logic ack_exp;
  logic [15:0] pkt_cnt;
  logic [15:0] abs_cnt;
  logic [15:0] ack_cnt;

  // read mux; status shows timer activity and the unsupported setting
  assign status_word = {28'h0000000,
    checksum_report_disable && (rx_desc_type == rximc_pkg::DTYPE_LEGACY),
    ack_run, abs_run, pkt_run};
  assign next_rdata =
    (i_paddr == rximc_pkg::ADDR_ABS_DELAY) ? {16'h0000, abs_delay} :
    (i_paddr == rximc_pkg::ADDR_PKT_DELAY) ? {16'h0000, pkt_delay} :
    (i_paddr == rximc_pkg::ADDR_SMALL_THR) ? {20'h00000, small_thr} :
    (i_paddr == rximc_pkg::ADDR_ACK_DELAY) ? {16'h0000, ack_delay} :
    (i_paddr == rximc_pkg::ADDR_CSUM_CTRL) ? {18'h00000, csum_ctrl} :
    (i_paddr == rximc_pkg::ADDR_AUX_CTRL) ? {23'h000000, aux_ctrl} :
    (i_paddr == rximc_pkg::ADDR_STATUS) ? status_word : 32'h00000000;

  // read data is captured in the setup cycle so it is a flop output
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_prdata <= 32'h00000000;
    else if (setup_ph)
      o_prdata <= next_rdata;
  end

  // register writes; the checksum control word is locked while receiving
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      abs_delay <= rximc_pkg::DELAY_RST;
      pkt_delay <= rximc_pkg::DELAY_RST;
      small_thr <= rximc_pkg::SMALL_THR_RST;
      ack_delay <= rximc_pkg::DELAY_RST;
      csum_ctrl <= rximc_pkg::CSUM_CTRL_RST;
      aux_ctrl <= rximc_pkg::AUX_CTRL_RST;
    end
    else if (wr_en)
    begin
      if (i_paddr == rximc_pkg::ADDR_ABS_DELAY)
        abs_delay <= i_pwdata[15:0];
      if (i_paddr == rximc_pkg::ADDR_PKT_DELAY)
        pkt_delay <= i_pwdata[15:0];
      if (i_paddr == rximc_pkg::ADDR_SMALL_THR)
        small_thr <= i_pwdata[11:0];
      if (i_paddr == rximc_pkg::ADDR_ACK_DELAY)
        ack_delay <= i_pwdata[15:0];
      if (i_paddr == rximc_pkg::ADDR_CSUM_CTRL && !rx_enable)
        csum_ctrl <= {i_pwdata[13:11], 1'b0, i_pwdata[9:0]};
      if (i_paddr == rximc_pkg::ADDR_AUX_CTRL)
        aux_ctrl <= i_pwdata[8:0];
    end
  end

  // shared prescaler: a fractional tick is not possible, so it rounds up
  logic [4:0] pre_cnt;
  assign tick = (pre_cnt == 5'(rximc_pkg::TICK_CYC - 1));
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      pre_cnt <= 5'h00;
    else
      pre_cnt <= tick ? 5'h00 : pre_cnt + 5'h01;
  end

  // timer control: packet and absolute expiry each reload and halt the other timer
  logic pkt_load;
  logic pkt_now;
  logic pkt_fire;
  logic abs_load;
  logic ack_evt;
  logic ack_now;
  logic ack_load;
  assign pkt_load = i_pkt_to_mem && (pkt_delay != 16'h0000);
  assign pkt_now = (i_pkt_to_mem && (pkt_delay == 16'h0000)) || fpd_wr;
  assign pkt_fire = pkt_exp || pkt_now;
  assign abs_load = i_pkt_to_mem && (abs_delay != 16'h0000) && !abs_run && !pkt_fire;
  assign ack_evt = i_ack_pkt && ack_irq_en;
  assign ack_now = ack_evt && (ack_delay == 16'h0000);
  assign ack_load = ack_evt && (ack_delay != 16'h0000) && !ack_run;

  rximc_delay_timer #(.W(16)) u_pkt_timer (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick),
    .i_load(pkt_load),
    .i_halt(abs_exp),
    .i_value(pkt_delay),
    .o_count(pkt_cnt),
    .o_running(pkt_run),
    .o_expire(pkt_exp)
  );

  rximc_delay_timer #(.W(16)) u_abs_timer (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick),
    .i_load(abs_load),
    .i_halt(pkt_fire),
    .i_value(abs_delay),
    .o_count(abs_cnt),
    .o_running(abs_run),
    .o_expire(abs_exp)
  );

  rximc_delay_timer #(.W(16)) u_ack_timer (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick),
    .i_load(ack_load),
    .i_halt(1'b0),
    .i_value(ack_delay),
    .o_count(ack_cnt),
    .o_running(ack_run),
    .o_expire(ack_exp)
  );

  // interrupt cause and flush pulses, one cycle after the cause
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_rx_timer_irq <= 1'b0;
      o_flush_wb <= 1'b0;
      o_ack_irq <= 1'b0;
    end
    else
    begin
      o_rx_timer_irq <= pkt_fire || abs_exp;
      o_flush_wb <= pkt_fire || abs_exp;
      o_ack_irq <= ack_now || ack_exp;
    end
  end

  // byte stream: position, length and raw sum
  logic [15:0] pos;
  logic [15:0] len;
  logic [15:0] sum;
  logic hi_next;
  logic strip_byte;
  logic [15:0] cur_pos;
  logic [15:0] cur_len;
  logic [15:0] cur_sum;
  logic cur_hi;
  logic [7:0] start_off;
  logic in_sum;
  logic [15:0] next_sum;
  logic [15:0] next_len;
  assign strip_byte = vlan_strip_en && i_rx_vlan_byte;
  assign cur_pos = i_rx_sop ? 16'h0000 : pos;
  assign cur_len = i_rx_sop ? 16'h0000 : len;
  assign cur_sum = i_rx_sop ? 16'h0000 : sum;
  assign cur_hi = i_rx_sop ? 1'b1 : hi_next;
  assign start_off = ip_payload_sum_mode ? i_l3_payload_off : checksum_start_byte;
  assign in_sum = !strip_byte && (cur_pos >= {8'h00, start_off})
    && !(strip_crc && i_rx_crc_byte);
  assign next_sum = in_sum
    ? csum_add(cur_sum, cur_hi ? {i_rx_data, 8'h00} : {8'h00, i_rx_data}) : cur_sum;
  assign next_len = strip_byte ? cur_len : cur_len + 16'h0001;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pos <= 16'h0000;
      len <= 16'h0000;
      sum <= 16'h0000;
      hi_next <= 1'b1;
    end
    else if (i_rx_valid)
    begin
      pos <= strip_byte ? cur_pos : cur_pos + 16'h0001;
      len <= next_len;
      sum <= next_sum;
      hi_next <= in_sum ? !cur_hi : cur_hi;
    end
  end

  // IP and L4 checks are gated by supported encapsulation; the CRC check is not
  logic eop_byte;
  logic v6_l4_ok;
  logic next_ip_err;
  logic next_l4_err;
  logic next_crc_err;
  logic [31:0] next_info;
  assign eop_byte = i_rx_valid && i_rx_eop;
  assign v6_l4_ok = i_is_ipv6 && !v6_filter_off && !v6_sum_off;
  assign next_ip_err = ip_hdr_check_en && i_encap_ok && i_is_ipv4 && !i_ip_hdr_ok;
  assign next_l4_err = l4_check_en && i_encap_ok && i_is_l4
    && (i_is_ipv4 || v6_l4_ok) && !i_l4_sum_ok;
  assign next_crc_err = crc32_check_en && !i_crc_ok;
  // hash only for the extended type; legacy always takes the checksum
  assign next_info = (checksum_report_disable && rx_desc_type == rximc_pkg::DTYPE_EXT)
    ? i_rss_hash : {i_ip_ident, next_sum};

  // descriptor fields and small packet pulse at end of packet
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_desc_valid <= 1'b0;
      o_desc_info <= 32'h00000000;
      o_desc_ip_err <= 1'b0;
      o_desc_l4_err <= 1'b0;
      o_desc_crc_err <= 1'b0;
      o_small_pkt_irq <= 1'b0;
    end
    else
    begin
      o_desc_valid <= eop_byte;
      o_small_pkt_irq <= eop_byte && small_pkt_en && (next_len <= {4'h0, small_thr});
      if (eop_byte)
      begin
        o_desc_info <= next_info;
        o_desc_ip_err <= next_ip_err;
        o_desc_l4_err <= next_l4_err;
        o_desc_crc_err <= next_crc_err;
      end
    end
  end

  property p_abs_off;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    (abs_delay == 16'h0000) && !abs_run |=> !abs_run;
  endproperty
  a_abs_off: assert property (p_abs_off) else $error("absolute timer ran while disabled");

  property p_abs_start;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    i_pkt_to_mem && !abs_run && (abs_delay != 16'h0000) && !pkt_fire
      |=> abs_run && (abs_cnt == $past(abs_delay));
  endproperty
  a_abs_start: assert property (p_abs_start) else $error("absolute timer not started");

  property p_abs_fire;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    abs_exp |=> o_rx_timer_irq && o_flush_wb && (!pkt_run || $past(i_pkt_to_mem));
  endproperty
  a_abs_fire: assert property (p_abs_fire) else $error("absolute expiry lost");

  property p_pkt_cancels_abs;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    pkt_fire |=> !abs_run && o_rx_timer_irq;
  endproperty
  a_pkt_cancels_abs: assert property (p_pkt_cancels_abs) else $error("absolute timer left running");

  property p_small;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    eop_byte && small_pkt_en && (next_len <= {4'h0, small_thr}) |=> o_small_pkt_irq;
  endproperty
  a_small: assert property (p_small) else $error("small packet missed");

  property p_ack_hold;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    ack_run && i_ack_pkt && !tick |=> ack_cnt == $past(ack_cnt);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack timer reloaded");

  property p_ack_zero;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    i_ack_pkt && ack_irq_en && (ack_delay == 16'h0000) |=> o_ack_irq;
  endproperty
  a_ack_zero: assert property (p_ack_zero) else $error("zero ack delay not immediate");

  property p_csum_reset;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    $fell(i_sys_rst) |-> csum_ctrl[rximc_pkg::CS_L4_EN] && csum_ctrl[rximc_pkg::CS_IP_EN];
  endproperty
  a_csum_reset: assert property (p_csum_reset) else $error("offload enables not set");

  property p_pkt_restart;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
    pkt_load |=> pkt_run && (pkt_cnt == $past(pkt_delay));
  endproperty
  a_pkt_restart: assert property (p_pkt_restart) else $error("packet timer not restarted");
endmodule // rximc_top
`default_nettype wire

// >>> tb/rximc_pkt_src.sv
// host-side receive path model: drives the byte stream one packet at a time
// assumes the bench calls send only after reset and never overlaps two calls
`timescale 1ns/10ps
`default_nettype none
module rximc_pkt_src (
  // clock
  input wire logic i_clk_sys,
  // byte stream
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_sop,
  output logic o_eop,
  output logic o_vlan,
  output logic o_crc
);
  // idle until the first packet
  initial
  begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_sop = 1'b0;
    o_eop = 1'b0;
    o_vlan = 1'b0;
    o_crc = 1'b0;
  end

  // byte i is i*19+5; bytes 12..15 form the tag, the last four the crc
  task automatic send(input int len, input bit vlan);
    for (int i = 0; i < len; i++)
    begin
      @(posedge i_clk_sys);
      o_valid <= 1'b1;
      o_data <= 8'(i * 19 + 5);
      o_sop <= (i == 0);
      o_eop <= (i == len - 1);
      o_vlan <= vlan && i >= 12 && i < 16;
      o_crc <= (i >= len - 4);
    end
    @(posedge i_clk_sys);
    o_valid <= 1'b0;
    o_data <= ~o_data; // no stale byte left on the idle lines
    o_sop <= 1'b0;
    o_eop <= 1'b0;
  endtask
endmodule // rximc_pkt_src
`default_nettype wire

// >>> tb/testbench.sv
// bench: apb register tasks, packet checks and timer scenarios
// assumes rximc_pkt_src stands in for the receive path feeding the block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic i_clk_sys, i_sys_rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [15:0] paddr, ident;
  logic [31:0] pwdata, prdata, rdata, hash, last_info, info;
  logic rv, sop, eop, vb, cb, encap, v4, v6, l4, ipok, l4ok, crcok, pkt, ack;
  logic dv, iperr, l4err, crcerr, tirq, flush, sirq, airq;
  logic [7:0] rd;
  logic [2:0] last_err;
  int cyc, n_small, n_tmr, n_ack, t_tmr, t_ack, t_pkt, t_ackin, base, t0;
  int n_errors, compares;

  rximc_pkt_src u_src (.i_clk_sys(i_clk_sys), .o_valid(rv), .o_data(rd), .o_sop(sop),
    .o_eop(eop), .o_vlan(vb), .o_crc(cb));

  rximc_top u_dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_rx_valid(rv),
    .i_rx_data(rd), .i_rx_sop(sop), .i_rx_eop(eop), .i_rx_vlan_byte(vb),
    .i_rx_crc_byte(cb), .i_l3_payload_off(8'h0E), .i_encap_ok(encap), .i_is_ipv4(v4),
    .i_is_ipv6(v6), .i_is_l4(l4), .i_ip_hdr_ok(ipok), .i_l4_sum_ok(l4ok),
    .i_crc_ok(crcok), .i_ip_ident(ident), .i_rss_hash(hash), .i_pkt_to_mem(pkt),
    .i_ack_pkt(ack), .o_desc_valid(dv), .o_desc_info(info), .o_desc_ip_err(iperr),
    .o_desc_l4_err(l4err), .o_desc_crc_err(crcerr), .o_rx_timer_irq(tirq),
    .o_flush_wb(flush), .o_small_pkt_irq(sirq), .o_ack_irq(airq));

  // 25 MHz clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  task automatic print_verdict;
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits for pready, the cycle ceiling bounds the wait
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    do
      @(posedge i_clk_sys);
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rdata, exp);
  endtask

  task automatic pulse(input logic sel_ack);
    @(posedge i_clk_sys);
    if (sel_ack)
      ack <= 1'b1;
    else
      pkt <= 1'b1;
    @(posedge i_clk_sys);
    ack <= 1'b0;
    pkt <= 1'b0;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  // raw sum from start byte, tag bytes stripped, crc bytes left out
  function automatic logic [15:0] exp_sum(input int len, input int start, input bit vlan);
    logic [16:0] s;
    logic [7:0] b;
    int p;
    bit hi;
    s = 17'h00000;
    p = 0;
    hi = 1'b1;
    for (int i = 0; i < len - 4; i++)
    begin
      if (!(vlan && i >= 12 && i < 16))
      begin
        b = 8'(i * 19 + 5);
        if (p >= start)
        begin
          s = s + (hi ? {1'b0, b, 8'h00} : {9'h000, b});
          s = {1'b0, s[15:0]} + 17'(s[16]);
          hi = !hi;
        end
        p++;
      end
    end
    return s[15:0];
  endfunction

  // monitor: records descriptor results, irq pulses and their times
  always @(posedge i_clk_sys)
  begin
    if (dv === 1'b1)
    begin
      last_info = info;
      last_err = {iperr, l4err, crcerr};
    end
    if (sirq === 1'b1)
      n_small++;
    if (tirq === 1'b1 || flush === 1'b1)
      check({31'h0, flush}, {31'h0, tirq});
    if (tirq === 1'b1)
    begin
      n_tmr++;
      t_tmr = cyc;
    end
    if (airq === 1'b1)
    begin
      n_ack++;
      t_ack = cyc;
    end
    if (pkt === 1'b1)
      t_pkt = cyc;
    if (ack === 1'b1)
      t_ackin = cyc;
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  // main sequence
  initial
  begin
    {psel, penable, pwrite, pkt, ack, encap, v4, v6, l4, ipok, l4ok, crcok} = '0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    ident = 16'hBEEF;
    hash = 32'h12345678;
    i_sys_rst = 1'b1;
    wait_cyc(4);
    i_sys_rst <= 1'b0;
    rd_chk(rximc_pkg::ADDR_ABS_DELAY, 32'h00000000);
    rd_chk(rximc_pkg::ADDR_ACK_DELAY, 32'h00000000);
    rd_chk(rximc_pkg::ADDR_CSUM_CTRL, 32'h00000300);
    rd_chk(16'h0004, 32'h00000000);
    check({31'h0, rerr}, 32'h00000001);
    apb(1'b1, rximc_pkg::ADDR_CSUM_CTRL, 32'h00000B02);
    apb(1'b1, rximc_pkg::ADDR_AUX_CTRL, 32'h0000018F);
    apb(1'b1, rximc_pkg::ADDR_SMALL_THR, 32'h00000028);
    {encap, v4, l4, ipok, l4ok, crcok} <= 6'b111010;
    u_src.send(44, 1'b1);
    wait_cyc(3);
    check(last_info, {16'hBEEF, exp_sum(44, 2, 1'b1)});
    check({29'h0, last_err}, 32'h00000005);
    check(32'(n_small), 32'h00000001);
    apb(1'b1, rximc_pkg::ADDR_SMALL_THR, 32'h00000027);
    {ipok, l4ok, crcok} <= 3'b101;
    u_src.send(44, 1'b1);
    wait_cyc(3);
    check({29'h0, last_err}, 32'h00000002);
    check(32'(n_small), 32'h00000001);
    apb(1'b1, rximc_pkg::ADDR_CSUM_CTRL, 32'h00002B02);
    rd_chk(rximc_pkg::ADDR_CSUM_CTRL, 32'h00000B02);
    apb(1'b1, rximc_pkg::ADDR_AUX_CTRL, 32'h0000018E);
    apb(1'b1, rximc_pkg::ADDR_CSUM_CTRL, 32'h00002B02);
    apb(1'b1, rximc_pkg::ADDR_AUX_CTRL, 32'h0000018F);
    {v4, v6, l4ok} <= 3'b010;
    u_src.send(20, 1'b0);
    wait_cyc(3);
    check(last_info, 32'h12345678);
    check({31'h0, last_err[1]}, 32'h00000001);
    apb(1'b1, rximc_pkg::ADDR_AUX_CTRL, 32'h000001CF);
    u_src.send(20, 1'b0);
    wait_cyc(3);
    check({31'h0, last_err[1]}, 32'h00000000);
    apb(1'b1, rximc_pkg::ADDR_AUX_CTRL, 32'h00000187);
    {encap, v4, v6, ipok} <= 4'b0100;
    u_src.send(20, 1'b0);
    wait_cyc(3);
    check({16'h0, last_info[15:0]}, {16'h0, exp_sum(20, 2, 1'b0)});
    check({30'h0, last_err[2:1]}, 32'h00000000);
    // payload mode: the sum starts at the upstream payload offset, not the start byte
    apb(1'b1, rximc_pkg::ADDR_AUX_CTRL, 32'h0000018E);
    apb(1'b1, rximc_pkg::ADDR_CSUM_CTRL, 32'h00001B02);
    apb(1'b1, rximc_pkg::ADDR_AUX_CTRL, 32'h0000018F);
    u_src.send(44, 1'b1);
    wait_cyc(3);
    check(last_info, {16'hBEEF, exp_sum(44, 14, 1'b1)});
    // ack timer: zero delay, then two ticks with a second ack ignored
    base = n_ack;
    pulse(1'b1);
    wait_cyc(3);
    check(32'(n_ack - base), 32'h00000001);
    check(32'(t_ack - t_ackin), 32'h00000001);
    apb(1'b1, rximc_pkg::ADDR_ACK_DELAY, 32'h00000002);
    base = n_ack;
    pulse(1'b1);
    wait_cyc(10);
    t0 = t_ackin;
    pulse(1'b1);
    wait_cyc(70);
    check(32'(n_ack - base), 32'h00000001);
    check(32'(t_ack - t0 >= 27 && t_ack - t0 <= 54), 32'h00000001);
    // absolute timer ends the burst; the packet timer must stay halted
    apb(1'b1, rximc_pkg::ADDR_PKT_DELAY, 32'h00000014);
    apb(1'b1, rximc_pkg::ADDR_ABS_DELAY, 32'h00000002);
    base = n_tmr;
    pulse(1'b0);
    wait_cyc(10);
    t0 = t_pkt;
    pulse(1'b0);
    wait_cyc(70);
    check(32'(n_tmr - base), 32'h00000001);
    check(32'(t_tmr - t0 >= 27 && t_tmr - t0 <= 54), 32'h00000001);
    wait_cyc(700);
    check(32'(n_tmr - base), 32'h00000001);
    // packet timer restarts, then its expiry halts the absolute timer
    apb(1'b1, rximc_pkg::ADDR_PKT_DELAY, 32'h00000003);
    apb(1'b1, rximc_pkg::ADDR_ABS_DELAY, 32'h00000008);
    base = n_tmr;
    pulse(1'b0);
    wait_cyc(20);
    pulse(1'b0);
    wait_cyc(300);
    t0 = t_pkt;
    check(32'(n_tmr - base), 32'h00000001);
    check(32'(t_tmr - t0 >= 53 && t_tmr - t0 <= 80), 32'h00000001);
    // flush write fires the receive timer cause at once; the flush bit reads 0
    base = n_tmr;
    apb(1'b1, rximc_pkg::ADDR_PKT_DELAY, 32'h80000003);
    wait_cyc(3);
    check(32'(n_tmr - base), 32'h00000001);
    rd_chk(rximc_pkg::ADDR_PKT_DELAY, 32'h00000003);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
